// file: logic/sensor_measurement_sequencer.sv
// Operation
// - One shared ten-bit converter, six channels
// - Fixed channel wiring per sensing element
// - Interface sequences pressure and acceleration capture
// - Processor directly powers temperature, voltage blocks
// - Power up, settle, then convert
// - Conversion aligned to sampling ticks
// - Completion raises wake-up interrupt
// - Pressure: power cell, capture, convert
// - Acceleration: power cell, capture, convert
// - Pressure and acceleration cells mutually exclusive
// - External pins measured against band-gap reference
// - Temperature sensor sits on channel one
// - Acceleration: step index, code, fault flag
`timescale 1ns/1ps
`include "smi_defs.svh"

module sensor_measurement_sequencer #(
    parameter int SETTLE_CYC = `SMI_SETTLE_CYC,
    parameter int SAMPLE_CYC = `SMI_SAMPLE_CYC,
    parameter int STEP_CYC   = `SMI_STEP_CYC,
    parameter int RES_BITS   = `SMI_RES_BITS,
    parameter int NUM_CHAN   = `SMI_NUM_CHAN
) (
    // Clock and reset
    input  wire logic                    mclk,
    input  wire logic                    rst,
    // Processor control bits
    input  wire logic                    req_valid,
    input  wire smi_pkg::meas_req_t      req,
    input  wire logic [4:0]              direct_pwr,
    input  wire logic                    irq_ack,
    // Processor status
    output logic                         busy_q,
    output logic                         irq_q,
    output logic [RES_BITS-1:0]          result_q,
    output smi_pkg::accel_rd_t           accel_q,
    output smi_pkg::meas_kind_t          done_kind_q,
    // Analog side
    output smi_pkg::cell_pwr_t           cell_pwr_q,
    output logic [NUM_CHAN-1:0]          chan_sel_q,
    output logic                         sample_q,
    output logic [3:0]                   offset_step_q,
    output logic [RES_BITS-1:0]          dac_code,
    input  wire logic                    comp_in
);

    // ****************************************************************
    // Decoding helpers
    // ****************************************************************
    // Channel of each kind, one-hot
    function automatic logic [NUM_CHAN-1:0] chan_of(
        input smi_pkg::meas_kind_t k);
        logic [2:0] n;
        n = `SMI_CHAN_ZERO;
        case (k)
            smi_pkg::KIND_TEMP:    n = `SMI_CHAN_ONE;
            smi_pkg::KIND_BANDGAP: n = `SMI_CHAN_TWO;
            smi_pkg::KIND_EXT0:    n = `SMI_CHAN_THREE;
            smi_pkg::KIND_EXT1:    n = `SMI_CHAN_FOUR;
            smi_pkg::KIND_REGMON:  n = `SMI_CHAN_FIVE;
            default:               n = `SMI_CHAN_ZERO;
        endcase
        return {{(NUM_CHAN-1){1'b0}}, 1'b1} << n;
    endfunction

    // Kinds sequenced through the transducer path
    function automatic logic is_seq(input smi_pkg::meas_kind_t k);
        return (k == smi_pkg::KIND_PRESSURE) ||
               (k == smi_pkg::KIND_ACCEL_X) ||
               (k == smi_pkg::KIND_ACCEL_Z);
    endfunction

    // ****************************************************************
    // State and wires
    // ****************************************************************
    localparam int DW = $clog2(SAMPLE_CYC + 1);

    smi_pkg::seq_state_t state_q;      // Sequencer state
    smi_pkg::seq_state_t state_d;
    smi_pkg::meas_kind_t kind_q;       // Kind being measured
    logic [DW-1:0]       div_q;        // Sampling divider
    logic                tick;         // Sampling rate enable
    logic                take_req;     // Request accepted
    logic                settle_done;  // Settling wait over
    logic                sar_start_q;  // Conversion start pulse
    logic                sar_busy;
    logic                sar_done;
    logic [RES_BITS-1:0] sar_result;
    logic                publish;      // Result goes out now
    logic                seq_on;       // Transducer cell powered
    logic [8:0]          acc_code;
    logic                acc_fault;

    assign tick      = (div_q == DW'(SAMPLE_CYC - 1));
    // Busy requests are dropped outright
    assign take_req  = req_valid && (state_q == smi_pkg::ST_IDLE);
    assign publish   = (state_q == smi_pkg::ST_DONE) && tick;
    assign seq_on    = (state_q != smi_pkg::ST_IDLE) && is_seq(kind_q);
    // Upper nine bits form the acceleration code
    assign acc_code  = sar_result[RES_BITS-1 -: 9];
    assign acc_fault = (acc_code == `SMI_ACC_CODE_LOW) ||
                       (acc_code == `SMI_ACC_CODE_HIGH);

    // ****************************************************************
    // Sampling divider, free running so every start meets a tick
    // ****************************************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            div_q <= '0;
        end else begin
            div_q <= tick ? '0 : div_q + DW'(1);
        end
    end

    // ****************************************************************
    // Sequencer next state
    // ****************************************************************
    always_comb begin
        state_d = state_q;
        case (state_q)
            smi_pkg::ST_IDLE: begin
                if (take_req) begin
                    state_d = smi_pkg::ST_SETTLE;
                end
            end
            smi_pkg::ST_SETTLE: begin
                if (settle_done) begin
                    state_d = smi_pkg::ST_ALIGN;
                end
            end
            smi_pkg::ST_ALIGN: begin
                if (tick) begin
                    state_d = smi_pkg::ST_SAMPLE;
                end
            end
            smi_pkg::ST_SAMPLE: begin
                if (tick) begin
                    state_d = smi_pkg::ST_CONVERT;
                end
            end
            smi_pkg::ST_CONVERT: begin
                if (sar_done) begin
                    state_d = smi_pkg::ST_DONE;
                end
            end
            smi_pkg::ST_DONE: begin
                // End also lands on a sampling tick
                if (tick) begin
                    state_d = smi_pkg::ST_IDLE;
                end
            end
            default: begin
                state_d = smi_pkg::ST_IDLE;
            end
        endcase
    end

    // ****************************************************************
    // Sequencer registers
    // ****************************************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q     <= smi_pkg::ST_IDLE;
            kind_q      <= smi_pkg::KIND_PRESSURE;
            busy_q      <= 1'b0;
            sample_q    <= 1'b0;
            sar_start_q <= 1'b0;
        end else begin
            state_q     <= state_d;
            busy_q      <= (state_d != smi_pkg::ST_IDLE);
            // Hold the input only between two ticks
            sample_q    <= (state_d == smi_pkg::ST_SAMPLE);
            sar_start_q <= (state_q == smi_pkg::ST_SAMPLE) && tick;
            if (take_req) begin
                kind_q <= req.kind;
            end
        end
    end

    // ****************************************************************
    // Power and routing to the analog side
    // ****************************************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cell_pwr_q    <= '0;
            chan_sel_q    <= '0;
            offset_step_q <= `SMI_STEP_RESET;
        end else begin
            // One transducer cell at a time
            cell_pwr_q.pcell   <= seq_on &&
                (kind_q == smi_pkg::KIND_PRESSURE);
            cell_pwr_q.gcell   <= seq_on &&
                (kind_q != smi_pkg::KIND_PRESSURE);
            cell_pwr_q.gcell_z <= seq_on &&
                (kind_q == smi_pkg::KIND_ACCEL_Z);
            // Processor owns these blocks directly
            cell_pwr_q.temp    <= direct_pwr[0];
            cell_pwr_q.bandgap <= direct_pwr[1] || direct_pwr[2] ||
                                  direct_pwr[3];
            cell_pwr_q.ext0    <= direct_pwr[2];
            cell_pwr_q.ext1    <= direct_pwr[3];
            cell_pwr_q.regmon  <= direct_pwr[4];
            chan_sel_q <= (state_q == smi_pkg::ST_IDLE) ? '0
                                                       : chan_of(kind_q);
            if (take_req) begin
                offset_step_q <= req.step;
            end
        end
    end

    // ****************************************************************
    // Results and sticky interrupt
    // ****************************************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_q       <= 1'b0;
            result_q    <= `SMI_RESULT_RESET;
            accel_q     <= '0;
            done_kind_q <= smi_pkg::KIND_PRESSURE;
        end else begin
            // Set wins over acknowledge
            irq_q <= publish || (irq_q && !irq_ack);
            if (publish) begin
                result_q    <= sar_result;
                done_kind_q <= kind_q;
                accel_q     <= '{step:  offset_step_q,
                                 code:  acc_code,
                                 fault: acc_fault};
            end
        end
    end

    // ****************************************************************
    // Leaf blocks
    // ****************************************************************
    // Settling wait after power-up
    settle_timer #(
        .CYCLES (SETTLE_CYC)
    ) u_settle (
        .mclk   (mclk),
        .rst    (rst),
        .start  (take_req),
        .done_q (settle_done)
    );

    // Shared converter, all channels go through it
    sar_converter #(
        .BITS       (RES_BITS),
        .STEP_CYC   (STEP_CYC)
    ) u_sar (
        .mclk       (mclk),
        .rst        (rst),
        .start      (sar_start_q),
        .busy_q     (sar_busy),
        .done_q     (sar_done),
        .comp_in    (comp_in),
        .dac_code_q (dac_code),
        .result_q   (sar_result)
    );

    // ****************************************************************
    // Checks
    // ****************************************************************
    int unsigned settle_cnt_q;   // Cycles spent in settle state

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            settle_cnt_q <= 0;
        end else if (state_q == smi_pkg::ST_SETTLE) begin
            settle_cnt_q <= settle_cnt_q + 1;
        end else begin
            settle_cnt_q <= 0;
        end
    end

    property p_settle_len;
        @(posedge mclk) disable iff (rst)
        (state_q == smi_pkg::ST_SETTLE) &&
        (state_d == smi_pkg::ST_ALIGN) |-> settle_cnt_q >= SETTLE_CYC - 1;
    endproperty
    a_settle_len: assert property (p_settle_len)
        else $error("Conversion approached before settling");

    property p_one_cell;
        @(posedge mclk) disable iff (rst)
        !(cell_pwr_q.pcell && cell_pwr_q.gcell);
    endproperty
    a_one_cell: assert property (p_one_cell)
        else $error("Both transducer cells powered");

    property p_ignore_busy;
        @(posedge mclk) disable iff (rst)
        busy_q && req_valid |=> $stable(kind_q);
    endproperty
    a_ignore_busy: assert property (p_ignore_busy)
        else $error("Request taken while busy");

    property p_irq_sticky;
        @(posedge mclk) disable iff (rst)
        irq_q && !irq_ack |=> irq_q;
    endproperty
    a_irq_sticky: assert property (p_irq_sticky)
        else $error("Interrupt dropped without acknowledge");

    property p_irq_on_done;
        @(posedge mclk) disable iff (rst)
        sar_start_q |-> ##[1:400] $rose(irq_q) || irq_q;
    endproperty
    a_irq_on_done: assert property (p_irq_on_done)
        else $error("No interrupt after conversion");

    property p_start_after_sample;
        @(posedge mclk) disable iff (rst)
        sar_start_q |-> $past(sample_q) && !sample_q;
    endproperty
    a_start_after_sample: assert property (p_start_after_sample)
        else $error("Conversion not aligned to sample end");

    property p_chan_route;
        @(posedge mclk) disable iff (rst)
        sar_busy |-> chan_sel_q == chan_of(kind_q);
    endproperty
    a_chan_route: assert property (p_chan_route)
        else $error("Wrong converter channel during conversion");

    property p_cell_on_conv;
        @(posedge mclk) disable iff (rst)
        sar_busy && is_seq(kind_q) |->
            cell_pwr_q.pcell || cell_pwr_q.gcell;
    endproperty
    a_cell_on_conv: assert property (p_cell_on_conv)
        else $error("Transducer cell off during conversion");

    property p_accel_fault;
        @(posedge mclk) disable iff (rst)
        publish |=> accel_q.fault ==
            ((accel_q.code == 9'h000) || (accel_q.code == 9'h1ff));
    endproperty
    a_accel_fault: assert property (p_accel_fault)
        else $error("Acceleration fault flag wrong");

    c_pressure: cover property (@(posedge mclk) disable iff (rst)
        publish && kind_q == smi_pkg::KIND_PRESSURE);
    c_accel_fault: cover property (@(posedge mclk) disable iff (rst)
        publish && acc_fault && kind_q == smi_pkg::KIND_ACCEL_Z);
    c_busy_req: cover property (@(posedge mclk) disable iff (rst)
        busy_q && req_valid);
    c_ack_race: cover property (@(posedge mclk) disable iff (rst)
        publish && irq_ack);

endmodule

// file: logic/smi_defs.svh
`ifndef SMI_DEFS_SVH
`define SMI_DEFS_SVH

// ********************************************************************
// Clock and timing figures
// ********************************************************************
// Clock period in picoseconds (200 MHz)
`define SMI_CLK_PERIOD_PS 5000
// Least settling time of a powered analog block, in ns
`define SMI_SETTLE_NS 2000
// Settling cycles, rounded up
`define SMI_SETTLE_CYC \
    ((`SMI_SETTLE_NS * 1000 + `SMI_CLK_PERIOD_PS - 1) / `SMI_CLK_PERIOD_PS)
// Sampling period of the input voltage, in ns
`define SMI_SAMPLE_NS 500
// Sampling period in cycles, rounded down
`define SMI_SAMPLE_CYC ((`SMI_SAMPLE_NS * 1000) / `SMI_CLK_PERIOD_PS)
// Time given to one bit trial, in ns
`define SMI_STEP_NS 100
// Bit trial cycles, rounded up
`define SMI_STEP_CYC \
    ((`SMI_STEP_NS * 1000 + `SMI_CLK_PERIOD_PS - 1) / `SMI_CLK_PERIOD_PS)

// ********************************************************************
// Converter shape and channel numbers
// ********************************************************************
`define SMI_NUM_CHAN 6
`define SMI_RES_BITS 10
`define SMI_CHAN_ZERO 3'h0
`define SMI_CHAN_ONE 3'h1
`define SMI_CHAN_TWO 3'h2
`define SMI_CHAN_THREE 3'h3
`define SMI_CHAN_FOUR 3'h4
`define SMI_CHAN_FIVE 3'h5

// ********************************************************************
// Acceleration reading limits and reset values
// ********************************************************************
`define SMI_ACC_CODE_LOW 9'h000
`define SMI_ACC_CODE_HIGH 9'h1ff
`define SMI_STEP_RESET 4'h0
`define SMI_RESULT_RESET 10'h000

`endif

// file: logic/smi_pkg.sv
package smi_pkg;

    // ****************************************************************
    // Measurement kinds
    // ****************************************************************
    typedef enum logic [2:0] {
        KIND_PRESSURE = 3'b000,
        KIND_ACCEL_X  = 3'b001,
        KIND_ACCEL_Z  = 3'b010,
        KIND_TEMP     = 3'b011,
        KIND_BANDGAP  = 3'b100,
        KIND_EXT0     = 3'b101,
        KIND_EXT1     = 3'b110,
        KIND_REGMON   = 3'b111
    } meas_kind_t;

    // ****************************************************************
    // Sequencer states
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_SETTLE  = 3'b001,
        ST_ALIGN   = 3'b010,
        ST_SAMPLE  = 3'b011,
        ST_CONVERT = 3'b100,
        ST_DONE    = 3'b101
    } seq_state_t;

    // ****************************************************************
    // Carried groups
    // ****************************************************************
    // Power enables of the analog blocks
    typedef struct packed {
        logic pcell;
        logic gcell;
        logic gcell_z;
        logic temp;
        logic bandgap;
        logic ext0;
        logic ext1;
        logic regmon;
    } cell_pwr_t;

    // Processor request
    typedef struct packed {
        meas_kind_t kind;
        logic [3:0] step;
    } meas_req_t;

    // Acceleration reading
    typedef struct packed {
        logic [3:0] step;
        logic [8:0] code;
        logic       fault;
    } accel_rd_t;

endpackage

// file: logic/settle_timer.sv
`timescale 1ns/1ps
`include "smi_defs.svh"

module settle_timer #(
    parameter int CYCLES = `SMI_SETTLE_CYC
) (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst,
    // Control
    input  wire logic start,
    output logic      done_q
);

    localparam int W = $clog2(CYCLES + 1);

    logic [W-1:0] cnt_q;     // Cycles spent settling
    logic         run_q;     // Timer running
    logic         last;      // Final cycle of the wait

    assign last = run_q && (cnt_q == W'(CYCLES - 1));

    // ****************************************************************
    // Up-count of the settling wait, from zero
    // ****************************************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_q  <= '0;
            run_q  <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= last;
            if (start) begin
                // Restart wins so a new power-up always waits in full
                cnt_q <= '0;
                run_q <= 1'b1;
            end else if (last) begin
                run_q <= 1'b0;
            end else if (run_q) begin
                cnt_q <= cnt_q + W'(1);
            end
        end
    end

endmodule

// file: logic/sar_converter.sv
`timescale 1ns/1ps
`include "smi_defs.svh"

module sar_converter #(
    parameter int BITS     = `SMI_RES_BITS,
    parameter int STEP_CYC = `SMI_STEP_CYC
) (
    // Clock and reset
    input  wire logic            mclk,
    input  wire logic            rst,
    // Control
    input  wire logic            start,
    output logic                 busy_q,
    output logic                 done_q,
    // Analog side
    input  wire logic            comp_in,
    output logic [BITS-1:0]      dac_code_q,
    // Result
    output logic [BITS-1:0]      result_q
);

    localparam int SW = $clog2(STEP_CYC + 1);
    localparam int IW = $clog2(BITS);

    logic            sync1_q;   // First stage, read only by second
    logic            sync2_q;
    logic            sync3_q;
    logic            comp_q;    // Accepted comparator level
    logic [IW-1:0]   idx_q;     // Bit under trial
    logic [SW-1:0]   step_q;    // Cycles into current trial
    logic [BITS-1:0] mask;
    logic [BITS-1:0] kept;
    logic [BITS-1:0] next_dac;
    logic            trial_end;

    assign mask      = {{(BITS-1){1'b0}}, 1'b1} << idx_q;
    assign kept      = comp_q ? dac_code_q : (dac_code_q & ~mask);
    assign next_dac  = kept | (mask >> 1);
    assign trial_end = busy_q && (step_q == SW'(STEP_CYC - 1));

    // ****************************************************************
    // Comparator synchroniser, level taken when stages two and three agree
    // ****************************************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
            comp_q  <= 1'b0;
        end else begin
            sync1_q <= comp_in;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            if (sync2_q == sync3_q) begin
                comp_q <= sync3_q;
            end
        end
    end

    // ****************************************************************
    // Successive approximation, most significant bit first
    // ****************************************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            busy_q     <= 1'b0;
            done_q     <= 1'b0;
            idx_q      <= '0;
            step_q     <= '0;
            dac_code_q <= '0;
            result_q   <= '0;
        end else begin
            done_q <= 1'b0;
            if (start && !busy_q) begin
                busy_q     <= 1'b1;
                idx_q      <= IW'(BITS - 1);
                step_q     <= '0;
                dac_code_q <= {1'b1, {(BITS-1){1'b0}}};
            end else if (trial_end) begin
                step_q <= '0;
                if (idx_q == '0) begin
                    // Last bit decided
                    busy_q     <= 1'b0;
                    done_q     <= 1'b1;
                    result_q   <= kept;
                    dac_code_q <= kept;
                end else begin
                    idx_q      <= idx_q - IW'(1);
                    dac_code_q <= next_dac;
                end
            end else if (busy_q) begin
                step_q <= step_q + SW'(1);
            end
        end
    end

endmodule

// file: bench/analog_front.sv
`timescale 1ns/1ps
// ****************************************
// Powered sensing elements and comparator
// ****************************************
module analog_front (
    // Clock
    input  wire logic               mclk,
    // Converter side
    input  wire smi_pkg::cell_pwr_t pwr,
    input  wire logic [5:0]         chan,
    input  wire logic [9:0]         dac,
    output logic                    comp_in
);
    logic       tog = 1'b0; // Unpowered input wanders, never holds
    logic       on;         // Selected element has power
    logic [9:0] lvl;        // Level of the selected element
    // Wandering level so no settled unknown can pass
    always_ff @(posedge mclk) begin
        tog <= ~tog;
    end
    // Channel zero is the shared transducer path
    assign on = chan[0] ? (pwr.pcell | pwr.gcell) :
                chan[1] ? pwr.temp : chan[2] ? pwr.bandgap :
                chan[3] ? pwr.ext0 : chan[4] ? pwr.ext1 :
                pwr.regmon;
    // Pressure near zero, X axis near one third scale, Z axis at full scale
    assign lvl = chan[0] ? (pwr.gcell_z ? 10'h3ff : pwr.gcell ? 10'h155 :
                 10'h001) : {chan, 4'h9};
    // Strict compare: high while input sits above the trial code
    assign comp_in = on ? (lvl > dac) : tog;
endmodule

// file: bench/sensor_measurement_sequencer_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_count++; \
    $display("unexpected at %0t: %h %h", $time, a, e); end end
module sensor_measurement_sequencer_tb;
    // ****************************************
    // Stimulus and observed outputs
    // ****************************************
    logic                mclk = 1'b0; // 200 MHz
    logic                rst;         // Async, active high
    logic                req_valid;   // Request strobe
    smi_pkg::meas_req_t  req;         // Kind and step
    logic [4:0]          direct_pwr;  // Processor power bits
    logic                irq_ack;     // Interrupt clear
    logic                busy_q;
    logic                irq_q;
    logic [9:0]          result_q;
    smi_pkg::accel_rd_t  accel_q;
    smi_pkg::meas_kind_t done_kind_q;
    smi_pkg::cell_pwr_t  cell_pwr_q;
    logic [5:0]          chan_sel_q;
    logic                sample_q;
    logic [3:0]          offset_step_q;
    logic [9:0]          dac_code;
    logic                comp_in;
    int                  err_count = 0;
    int                  comparisons = 0;
    // Short counts keep the run brief
    sensor_measurement_sequencer #(.SETTLE_CYC(8), .SAMPLE_CYC(4),
        .STEP_CYC(6)) dut_u (.mclk, .rst, .req_valid, .req, .direct_pwr,
        .irq_ack, .busy_q, .irq_q, .result_q, .accel_q, .done_kind_q,
        .cell_pwr_q, .chan_sel_q, .sample_q, .offset_step_q, .dac_code,
        .comp_in);
    analog_front af_u (.mclk, .pwr(cell_pwr_q), .chan(chan_sel_q),
        .dac(dac_code), .comp_in);
    initial begin
        forever #2.5 mclk = ~mclk;
    end
    // ****************************************
    // Closing report
    // ****************************************
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // One measurement; a second request lands while busy
    task automatic measure(input int k, input logic [4:0] dp);
        int         n;
        int         ch;
        int         s;
        int         w;
        logic [9:0] er;
        logic [7:0] ep;
        ch = (k < 3) ? 0 : k - 2;
        s = 0;
        w = 0;
        er = (k == 0) ? 10'h000 : (k == 1) ? 10'h154 :
             (k == 2) ? 10'h3fe : {6'(1 << ch), 4'h9} - 10'h001;
        // Cell power order: pcell gcell gcell_z temp bandgap ext0 ext1 regmon
        ep = {(k == 0), (k inside {1, 2}), (k == 2), dp[0], |dp[3:1],
              dp[2], dp[3], dp[4]};
        @(negedge mclk);
        direct_pwr = dp;
        req = '{kind: smi_pkg::meas_kind_t'(k), step: 4'(k + 8)};
        req_valid = 1'b1;
        @(negedge mclk);
        req = '{kind: smi_pkg::KIND_REGMON, step: 4'h3};
        `CHK(busy_q, 1'b1)
        @(negedge mclk);
        req_valid = 1'b0;
        // Routing and cell power follow one cycle after busy
        `CHK(chan_sel_q, 6'(1 << ch))
        `CHK(cell_pwr_q.pcell, k == 0)
        `CHK(cell_pwr_q.gcell, k inside {1, 2})
        `CHK(cell_pwr_q, ep)
        `CHK(offset_step_q, 4'(k + 8))
        // Count sampling cycles and note when sampling first starts
        for (n = 0; n < 400 && irq_q !== 1'b1; n++) begin
            @(negedge mclk);
            if (sample_q === 1'b1 && s == 0) begin
                w = n;
            end
            s += int'(sample_q === 1'b1);
        end
        if (n == 400) begin
            err_count++;
            report_and_stop();
        end
        `CHK(busy_q, 1'b0)
        `CHK(done_kind_q, smi_pkg::meas_kind_t'(k))
        `CHK(result_q, er)
        `CHK(accel_q, {4'(k + 8), er[9:1], er[9:1] inside {0, 511}})
        `CHK(dac_code, er)
        `CHK(s, 4)
        // Cell powered a cycle after take, then eight settling cycles
        `CHK(w >= 7, 1'b1)
        repeat (3) @(negedge mclk);
        `CHK(irq_q, 1'b1)
        `CHK(chan_sel_q, 6'h00)
        `CHK(cell_pwr_q.pcell | cell_pwr_q.gcell, 1'b0)
        irq_ack = 1'b1;
        @(negedge mclk);
        irq_ack = 1'b0;
        `CHK(irq_q, 1'b0)
    endtask
    // Reset, then every kind in turn, one at a time
    initial begin
        rst = 1'b1;
        req_valid = 1'b0;
        req = '0;
        direct_pwr = 5'h00;
        irq_ack = 1'b0;
        repeat (3) @(negedge mclk);
        `CHK(irq_q, 1'b0)
        rst = 1'b0;
        for (int k = 0; k < 8; k++) begin
            measure(k, (k < 3) ? 5'h00 : 5'(1 << (k - 3)));
        end
        report_and_stop();
    end
endmodule
